/* File: src/dlst_defines.svh */
// Constants of the datacomm loopback self-test: timing, codes, baud table.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef DLST_DEFINES_SVH
`define DLST_DEFINES_SVH

// Clock
`define DLST_CLK_HZ 50000000
`define DLST_CLK_PERIOD_NS 20

// Baud tolerance, in percent either side of the configured rate
`define DLST_TOL_PCT 2

// Control line settle time before the loopback is sampled
`define DLST_CTL_SETTLE_NS 1000
`define DLST_CTL_SETTLE_CYC ((`DLST_CTL_SETTLE_NS + `DLST_CLK_PERIOD_NS - 1) / `DLST_CLK_PERIOD_NS)

// Printer pattern interval in the manufacturing loop
`define DLST_PRINT_MIN 30
`define DLST_PRINT_CYC (64'd`DLST_PRINT_MIN * 64'd60 * 64'd1000000000 / 64'd`DLST_CLK_PERIOD_NS)

// Supported rates, in bits per second, indexed by rate select
`define DLST_NUM_RATES 8
`define DLST_BAUD0 110
`define DLST_BAUD1 300
`define DLST_BAUD2 600
`define DLST_BAUD3 1200
`define DLST_BAUD4 2400
`define DLST_BAUD5 4800
`define DLST_BAUD6 9600
`define DLST_BAUD7 19200

// Baud measurement length in generator periods
`define DLST_NPER 4
// Characters sent in the data loopback check
`define DLST_NCHAR 4
// Loopback timeout, in bit times of the rate under test
`define DLST_LOOP_BITS 12
// First data pattern; later characters are this value xor the index
`define DLST_DATA_SEED 8'h55

// Error codes shown after the port name
`define DLST_ERR_NOCONN 4'h1
`define DLST_ERR_FAST 4'h2
`define DLST_ERR_SLOW 4'h3
`define DLST_ERR_CTL 4'h4
`define DLST_ERR_NOLOOP 4'h5
`define DLST_ERR_DATA 4'h6
`define DLST_ERR_FRAME 4'h7
`define DLST_ERR_OVERRUN 4'h8

`endif

/* File: src/dlst_pkg.sv */
// Types of the datacomm loopback self-test.
// Assumes dlst_defines.svh holds every number.
package dlst_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_BOOT, ST_IDLE, ST_FB, ST_HB, ST_FOCUS, ST_LIST, ST_CTL_SET, ST_CTL_CHK,
    ST_BAUD_GO, ST_BAUD_WAIT, ST_TX, ST_RX, ST_ROUND, ST_PASS, ST_FAIL
  } dlst_state_t;

  // Screen pattern selection
  typedef enum logic [1:0] {
    PAT_NONE, PAT_FULL_INV, PAT_HALF_INV, PAT_AT_SIGNS
  } dlst_pat_t;

endpackage

/* File: src/dlst_baud_check.sv */
// Baud generator rate check: measures the tick period against the expected one.
// Assumes tick is a one-cycle pulse on clk from the baud generator.
`timescale 1ns/1ns
`include "dlst_defines.svh"

module dlst_baud_check import dlst_pkg::*; #(
  parameter int NPER = `DLST_NPER
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request
  input wire logic start,
  input wire logic tick,
  input wire logic [19:0] exp_per,
  // Result
  output logic done,
  output logic fast,
  output logic slow
);

  logic busy_q, busy_d; // Measurement in progress
  logic armed_q, armed_d; // First tick seen
  logic [3:0] n_q, n_d; // Periods counted
  logic [27:0] cnt_q, cnt_d; // Cycles since first tick
  logic done_d, fast_d, slow_d;
  logic [35:0] tot; // Expected cycles for NPER periods
  logic [35:0] meas; // Measured cycles

  assign tot = 36'(exp_per) * 36'(NPER);
  assign meas = 36'(cnt_q) + 36'd1;

  // Next state of the measurement
  always_comb begin
    busy_d = busy_q;
    armed_d = armed_q;
    n_d = n_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    fast_d = fast;
    slow_d = slow;
    if (start) begin
      // Restart and clear the verdict
      busy_d = 1'b1;
      armed_d = 1'b0;
      n_d = 4'h0;
      cnt_d = 28'h0;
      fast_d = 1'b0;
      slow_d = 1'b0;
    end else if (busy_q) begin
      if (armed_q) begin
        cnt_d = cnt_q + 28'h1;
      end
      if (tick && !armed_q) begin
        // Measurement opens on the first tick
        armed_d = 1'b1;
        cnt_d = 28'h0;
      end else if (tick) begin
        n_d = n_q + 4'h1;
        if (32'(n_q) + 1 == NPER) begin
          // Verdict against plus or minus the tolerance
          busy_d = 1'b0;
          done_d = 1'b1;
          fast_d = (meas * 36'd100) < (tot * 36'(100 - `DLST_TOL_PCT));
          slow_d = (meas * 36'd100) > (tot * 36'(100 + `DLST_TOL_PCT));
        end
      end else if (36'(cnt_q) > (tot << 1)) begin
        // A generator that stalls after its first tick counts as too slow
        busy_d = 1'b0;
        done_d = 1'b1;
        slow_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      armed_q <= 1'b0;
      n_q <= 4'h0;
      cnt_q <= 28'h0;
      done <= 1'b0;
      fast <= 1'b0;
      slow <= 1'b0;
    end else begin
      busy_q <= busy_d;
      armed_q <= armed_d;
      n_q <= n_d;
      cnt_q <= cnt_d;
      done <= done_d;
      fast <= fast_d;
      slow <= slow_d;
    end
  end

endmodule // dlst_baud_check

/* File: src/dlst_self_test.sv */
// Datacomm loopback self-test and looping manufacturing test sequencer.
// Assumes a serial port, display and non-volatile store on the same clock;
// only the loopback connector sense and control line returns are pins.
//
// Overview of operation
// - Control lines, then baud, then data loopback
// - Baud passes only within two percent
// - All checks run with asynchronous framing
// - Standalone checks current rate; manufacturing sweeps all for baud, data loopback at 19200
// - Code 1 no connector; ignored with modem
// - Code 2 fast, 3 slow, 4 control lines
// - Code 5 when character never returns
// - Code 6 when returned character differs
// - Code 7 framing, code 8 overrun
// - Error names port plus code; port set only at standalone start or halted restore
// - Blank screen, show testing until done
// - Pass: one beep, restore labels, exit
// - Refuse start unless enabled in configuration
// - Manufacturing loops forever; print every thirty minutes
// - Manufacturing error halts, stored, restored halted
// - Pause on each recorded error until acknowledged
// - Power cycle resumes the manufacturing sequence
// - Hard reset ends sequence, clears screen
// - Soft reset restarts at full-bright inverse
`timescale 1ns/1ns
`include "dlst_defines.svh"

module dlst_self_test import dlst_pkg::*; #(
  parameter int NUM_RATES = `DLST_NUM_RATES,
  parameter int NCHAR = `DLST_NCHAR,
  parameter longint unsigned PRINT_CYC = `DLST_PRINT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Operator keys and configuration
  input wire logic start_req,
  input wire logic mfg_req,
  input wire logic cfg_enable,
  input wire logic port_sel,
  input wire logic [2:0] cur_rate,
  input wire logic modem_mode,
  input wire logic ack_key,
  input wire logic soft_rst,
  input wire logic hard_rst,
  // Loopback pins
  input wire logic conn_present_pin,
  input wire logic [1:0] ctl_in_pin,
  output logic [1:0] ctl_out,
  // Serial port control and data
  output logic async_mode,
  output logic [2:0] baud_sel,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_frame_err,
  input wire logic rx_overrun,
  input wire logic baud_tick,
  // Display, keyboard and printer
  output logic screen_blank,
  output logic testing_msg,
  output dlst_pat_t pattern_sel,
  output logic status_show,
  output logic beep,
  output logic restore_keys,
  output logic test_mode,
  output logic err_valid,
  output logic [3:0] err_code,
  output logic err_port,
  output logic screen_clear,
  output logic print_req,
  // Non-volatile store
  input wire logic nv_mfg_in,
  input wire logic nv_halt_in,
  input wire logic [3:0] nv_halt_code,
  input wire logic nv_halt_port,
  input wire logic [3:0] nv_rec_count,
  input wire logic [3:0] nv_rd_code,
  output logic [3:0] nv_rd_idx,
  output logic nv_wr,
  output logic nv_wr_halt,
  output logic nv_mfg_out
);

  // Pin synchronisers: bit 2 connector sense, bits 1:0 control returns
  logic [2:0] pin_in, s1_q, s2_q, s3_q, stab_q;
  assign pin_in = {conn_present_pin, ctl_in_pin};

  // One three-stage chain per pin; a level is taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          stab_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            stab_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Expected baud generator period in clocks for each rate
  function automatic logic [19:0] per_of(input logic [2:0] r);
    case (r)
      3'h0: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD0);
      3'h1: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD1);
      3'h2: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD2);
      3'h3: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD3);
      3'h4: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD4);
      3'h5: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD5);
      3'h6: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD6);
      default: per_of = 20'(`DLST_CLK_HZ / `DLST_BAUD7);
    endcase
  endfunction

  // Sequencer state
  dlst_state_t st_q, st_d; // Current step
  logic mfg_q, mfg_d; // Manufacturing loop active
  logic [3:0] idx_q, idx_d; // Pattern, character or record index
  logic [23:0] tmr_q, tmr_d; // Settle and timeout counter
  logic [63:0] prt_q, prt_d; // Time since last printer patterns
  logic [1:0] ctl_out_d;
  logic async_d, tx_valid_d, blank_d, testing_d, status_d, beep_d, restore_d;
  logic test_mode_d, err_valid_d, err_port_d, clear_d, print_d;
  logic nv_wr_d, nv_wr_halt_d, nv_mfg_d;
  logic [2:0] baud_sel_d;
  logic [7:0] tx_data_d;
  logic [3:0] err_code_d;
  dlst_pat_t pat_d;
  logic fail_en; // A check failed this cycle
  logic [3:0] fail_c; // Its code
  logic bchk_start, bchk_done, bchk_fast, bchk_slow;

  // Baud rate measurement
  dlst_baud_check #(
    .NPER(`DLST_NPER)
  ) u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .start(bchk_start),
    .tick(baud_tick),
    .exp_per(per_of(baud_sel)),
    .done(bchk_done),
    .fast(bchk_fast),
    .slow(bchk_slow)
  );

  // Next values of the sequencer and all its outputs
  always_comb begin
    st_d = st_q;
    mfg_d = mfg_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    prt_d = mfg_q ? prt_q + 64'h1 : 64'h0;
    ctl_out_d = ctl_out;
    async_d = async_mode;
    baud_sel_d = baud_sel;
    tx_data_d = tx_data;
    blank_d = screen_blank;
    testing_d = testing_msg;
    pat_d = pattern_sel;
    test_mode_d = test_mode;
    err_valid_d = err_valid;
    err_code_d = err_code;
    err_port_d = err_port;
    nv_mfg_d = nv_mfg_out;
    nv_wr_halt_d = nv_wr_halt;
    // Pulses default low
    tx_valid_d = 1'b0;
    status_d = 1'b0;
    beep_d = 1'b0;
    restore_d = 1'b0;
    clear_d = 1'b0;
    print_d = 1'b0;
    nv_wr_d = 1'b0;
    bchk_start = 1'b0;
    fail_en = 1'b0;
    fail_c = 4'h0;
    case (st_q)
      // First cycle after reset: pick up what the store remembers
      ST_BOOT: begin
        if (nv_halt_in) begin
          st_d = ST_FAIL;
          mfg_d = nv_mfg_in;
          test_mode_d = 1'b1;
          err_valid_d = 1'b1;
          err_code_d = nv_halt_code;
          err_port_d = nv_halt_port;
          nv_mfg_d = nv_mfg_in;
        end else if (nv_mfg_in) begin
          // Power returned during the loop: carry on
          st_d = ST_CTL_SET;
          nv_mfg_d = 1'b1;
          mfg_d = 1'b1;
          test_mode_d = 1'b1;
          blank_d = 1'b1;
          testing_d = 1'b1;
          async_d = 1'b1;
          baud_sel_d = 3'h0;
          idx_d = 4'h0;
          print_d = 1'b1;
        end else begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (mfg_req) begin
          st_d = ST_FB;
          mfg_d = 1'b1;
          nv_mfg_d = 1'b1;
          nv_wr_d = 1'b1;
          test_mode_d = 1'b1;
          pat_d = PAT_FULL_INV;
        end else if (start_req && cfg_enable) begin
          st_d = ST_CTL_SET;
          mfg_d = 1'b0;
          err_port_d = port_sel;
          baud_sel_d = cur_rate;
          idx_d = 4'h0;
          test_mode_d = 1'b1;
          blank_d = 1'b1;
          testing_d = 1'b1;
          async_d = 1'b1;
        end
      end
      // Alignment patterns, each held until the operator continues
      ST_FB: if (ack_key) begin
        st_d = ST_HB;
        pat_d = PAT_HALF_INV;
      end
      ST_HB: if (ack_key) begin
        st_d = ST_FOCUS;
        pat_d = PAT_AT_SIGNS;
      end
      ST_FOCUS: if (ack_key) begin
        st_d = ST_LIST;
        pat_d = PAT_NONE;
        idx_d = 4'h0;
      end
      // Recorded errors, one at a time
      ST_LIST: begin
        if (idx_q == nv_rec_count) begin
          st_d = ST_CTL_SET;
          err_valid_d = 1'b0;
          blank_d = 1'b1;
          testing_d = 1'b1;
          async_d = 1'b1;
          baud_sel_d = 3'h0;
          print_d = 1'b1;
          prt_d = 64'h0;
        end else begin
          err_valid_d = 1'b1;
          err_code_d = nv_rd_code;
          if (ack_key) begin
            idx_d = idx_q + 4'h1;
            err_valid_d = 1'b0;
          end
        end
      end
      // Control line check: drive a pattern, let it settle, compare
      ST_CTL_SET: begin
        if (!stab_q[2] && !modem_mode) begin
          fail_en = 1'b1;
          fail_c = `DLST_ERR_NOCONN;
        end else begin
          ctl_out_d = idx_q[1:0];
          tmr_d = 24'h0;
          st_d = ST_CTL_CHK;
        end
      end
      ST_CTL_CHK: begin
        tmr_d = tmr_q + 24'h1;
        if (tmr_q == 24'(`DLST_CTL_SETTLE_CYC)) begin
          if (stab_q[1:0] != ctl_out) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_CTL;
          end else if (idx_q == 4'h3) begin
            st_d = ST_BAUD_GO;
            ctl_out_d = 2'h0;
          end else begin
            idx_d = idx_q + 4'h1;
            st_d = ST_CTL_SET;
          end
        end
      end
      // Baud rate check at one rate
      ST_BAUD_GO: begin
        bchk_start = 1'b1;
        st_d = ST_BAUD_WAIT;
      end
      ST_BAUD_WAIT: begin
        if (bchk_done) begin
          if (bchk_fast) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_FAST;
          end else if (bchk_slow) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_SLOW;
          end else if (mfg_q && 32'(baud_sel) < NUM_RATES - 1) begin
            baud_sel_d = baud_sel + 3'h1;
            st_d = ST_BAUD_GO;
          end else begin
            idx_d = 4'h0;
            st_d = ST_TX;
          end
        end
      end
      // Data loopback: send, then wait for the echo
      ST_TX: begin
        tx_valid_d = 1'b1;
        tx_data_d = `DLST_DATA_SEED ^ {4'h0, idx_q};
        tmr_d = 24'h0;
        st_d = ST_RX;
      end
      ST_RX: begin
        tmr_d = tmr_q + 24'h1;
        if (rx_valid) begin
          if (rx_frame_err) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_FRAME;
          end else if (rx_overrun) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_OVERRUN;
          end else if (rx_data != tx_data) begin
            fail_en = 1'b1;
            fail_c = `DLST_ERR_DATA;
          end else if (32'(idx_q) == NCHAR - 1) begin
            st_d = mfg_q ? ST_ROUND : ST_PASS;
          end else begin
            idx_d = idx_q + 4'h1;
            st_d = ST_TX;
          end
        end else if (tmr_q == 24'(32'(per_of(baud_sel)) * `DLST_LOOP_BITS)) begin
          fail_en = 1'b1;
          fail_c = `DLST_ERR_NOLOOP;
        end
      end
      // End of one manufacturing round: status, printer when due, go again
      ST_ROUND: begin
        status_d = 1'b1;
        if (prt_q >= PRINT_CYC - 64'h1) begin
          print_d = 1'b1;
          prt_d = 64'h0;
        end
        baud_sel_d = 3'h0;
        idx_d = 4'h0;
        st_d = ST_CTL_SET;
      end
      ST_PASS: begin
        beep_d = 1'b1;
        restore_d = 1'b1;
        test_mode_d = 1'b0;
        blank_d = 1'b0;
        testing_d = 1'b0;
        async_d = 1'b0;
        st_d = ST_IDLE;
      end
      // Error held on screen until acknowledged
      ST_FAIL: begin
        if (ack_key) begin
          err_valid_d = 1'b0;
          if (mfg_q) begin
            nv_wr_d = 1'b1;
            nv_wr_halt_d = 1'b0;
            testing_d = 1'b1;
            blank_d = 1'b1;
            async_d = 1'b1;
            baud_sel_d = 3'h0;
            idx_d = 4'h0;
            st_d = ST_CTL_SET;
          end else begin
            restore_d = 1'b1;
            test_mode_d = 1'b0;
            blank_d = 1'b0;
            async_d = 1'b0;
            st_d = ST_IDLE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Any failed check halts and shows port and code
    if (fail_en) begin
      st_d = ST_FAIL;
      err_valid_d = 1'b1;
      err_code_d = fail_c;
      testing_d = 1'b0;
      ctl_out_d = 2'h0;
      if (mfg_q) begin
        nv_wr_d = 1'b1;
        nv_wr_halt_d = 1'b1;
      end
    end
    // Soft reset restarts the loop; hard reset ends it
    if (hard_rst && mfg_q) begin
      st_d = ST_IDLE;
      mfg_d = 1'b0;
      nv_mfg_d = 1'b0;
      nv_wr_halt_d = 1'b0;
      nv_wr_d = 1'b1;
      clear_d = 1'b1;
      err_valid_d = 1'b0;
      test_mode_d = 1'b0;
      blank_d = 1'b0;
      testing_d = 1'b0;
      async_d = 1'b0;
      pat_d = PAT_NONE;
      ctl_out_d = 2'h0;
    end else if (soft_rst && mfg_q) begin
      st_d = ST_FB;
      pat_d = PAT_FULL_INV;
      err_valid_d = 1'b0;
      blank_d = 1'b0;
      testing_d = 1'b0;
      ctl_out_d = 2'h0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_BOOT;
      mfg_q <= 1'b0;
      idx_q <= 4'h0;
      tmr_q <= 24'h0;
      prt_q <= 64'h0;
      ctl_out <= 2'h0;
      async_mode <= 1'b0;
      baud_sel <= 3'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h0;
      screen_blank <= 1'b0;
      testing_msg <= 1'b0;
      pattern_sel <= PAT_NONE;
      status_show <= 1'b0;
      beep <= 1'b0;
      restore_keys <= 1'b0;
      test_mode <= 1'b0;
      err_valid <= 1'b0;
      err_code <= 4'h0;
      err_port <= 1'b0;
      screen_clear <= 1'b0;
      print_req <= 1'b0;
      nv_wr <= 1'b0;
      nv_wr_halt <= 1'b0;
      nv_mfg_out <= 1'b0;
    end else begin
      st_q <= st_d;
      mfg_q <= mfg_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      prt_q <= prt_d;
      ctl_out <= ctl_out_d;
      async_mode <= async_d;
      baud_sel <= baud_sel_d;
      tx_valid <= tx_valid_d;
      tx_data <= tx_data_d;
      screen_blank <= blank_d;
      testing_msg <= testing_d;
      pattern_sel <= pat_d;
      status_show <= status_d;
      beep <= beep_d;
      restore_keys <= restore_d;
      test_mode <= test_mode_d;
      err_valid <= err_valid_d;
      err_code <= err_code_d;
      err_port <= err_port_d;
      screen_clear <= clear_d;
      print_req <= print_d;
      nv_wr <= nv_wr_d;
      nv_wr_halt <= nv_wr_halt_d;
      nv_mfg_out <= nv_mfg_d;
    end
  end

  assign nv_rd_idx = idx_q;

endmodule // dlst_self_test

/* File: sim/dlst_self_test_assertions.sv */
// Checker for the self-test sequencer, watching top-level ports only.
// Assumes one clock domain; bound to the sequencer at the foot of this file.
`timescale 1ns/1ns
module dlst_self_test_chk import dlst_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Operator inputs
  input wire logic start_req,
  input wire logic mfg_req,
  input wire logic cfg_enable,
  input wire logic ack_key,
  input wire logic soft_rst,
  input wire logic hard_rst,
  input wire logic [2:0] cur_rate,
  // Sequencer outputs
  input wire logic test_mode,
  input wire logic screen_blank,
  input wire logic testing_msg,
  input wire logic async_mode,
  input wire logic [2:0] baud_sel,
  input wire logic tx_valid,
  input wire logic beep,
  input wire logic restore_keys,
  input wire logic err_valid,
  input wire logic [3:0] err_code,
  input wire logic err_port,
  input wire dlst_pat_t pattern_sel,
  input wire logic screen_clear,
  input wire logic nv_mfg_out
);
  // High while nothing runs and a standalone start could be taken
  logic idle;
  assign idle = !test_mode && !err_valid && pattern_sel == PAT_NONE && !nv_mfg_out;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_start_refused: assert property (start_req && !cfg_enable && !mfg_req && idle |=> !test_mode)
    else $error("start taken while disabled");
  chk_start_taken: assert property (start_req && cfg_enable && !mfg_req && idle |=> ##[0:1] test_mode)
    else $error("enabled start not taken");
  chk_pass_once: assert property (beep |-> restore_keys && !test_mode ##1 !beep)
    else $error("pass indication wrong");
  chk_err_held: assert property (err_valid && !ack_key && !soft_rst && !hard_rst
    |=> err_valid && $stable(err_code) && $stable(err_port))
    else $error("error indication not held");
  chk_test_async: assert property (testing_msg |-> screen_blank && async_mode && test_mode)
    else $error("testing shown without blank async port");
  chk_tx_rate: assert property (tx_valid && !nv_mfg_out |-> baud_sel == cur_rate && async_mode)
    else $error("character sent at wrong rate");
  chk_hard_clear: assert property (pattern_sel != PAT_NONE && hard_rst |-> ##[1:2] screen_clear)
    else $error("hard reset kept screen");
  chk_soft_restart: assert property (pattern_sel != PAT_NONE && soft_rst && !hard_rst
    |-> ##[1:2] pattern_sel == PAT_FULL_INV)
    else $error("soft reset did not restart");
endmodule // dlst_self_test_chk

bind dlst_self_test dlst_self_test_chk u_chk (.*);

/* File: sim/dlst_loop_model.sv */
// Loopback hood model: returns control lines, baud ticks and echoed characters.
// Assumes mode names the fault to inject (0 clean) and dly the echo delay.
`timescale 1ns/1ns
`include "dlst_defines.svh"
module dlst_loop_model (
  // Clock, reset and fault control
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] mode,
  input wire logic [7:0] dly,
  // Block side of the port
  input wire logic [1:0] ctl_out,
  input wire logic [2:0] baud_sel,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic conn_present_pin,
  output logic [1:0] ctl_in_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err,
  output logic rx_overrun,
  output logic baud_tick
);
  localparam int RATE[8] = '{`DLST_BAUD0, `DLST_BAUD1, `DLST_BAUD2, `DLST_BAUD3,
    `DLST_BAUD4, `DLST_BAUD5, `DLST_BAUD6, `DLST_BAUD7};
  int base; // Nominal tick period in clocks
  int per; // Period skewed by the fast and slow faults
  int cnt_q; // Tick counter
  int wait_q; // Echo countdown, 0 when idle
  logic [7:0] chr_q; // Character held for echo

  // Generator rate, optionally off by ten percent
  assign base = `DLST_CLK_HZ / RATE[baud_sel];
  assign per = (mode == 4'h2) ? base * 9 / 10 : (mode == 4'h3) ? base * 11 / 10 : base;
  // Hood wires every driven line back; faults break one path each
  assign conn_present_pin = (mode != 4'h1);
  assign ctl_in_pin = (mode == 4'h4) ? ~ctl_out : ctl_out;
  // Data line shows the inverse of the echo outside the valid cycle, or inside it under fault 6
  assign rx_data = (rx_valid ^ (mode == 4'h6)) ? chr_q : ~chr_q;
  assign rx_frame_err = rx_valid && mode == 4'h7;
  assign rx_overrun = rx_valid && mode == 4'h8;

  // Tick generator and echo delay line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      wait_q <= 0;
      chr_q <= 8'h00;
      rx_valid <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= (cnt_q >= per - 1);
      cnt_q <= (cnt_q >= per - 1) ? 0 : cnt_q + 1;
      rx_valid <= (wait_q == 1);
      if (tx_valid && mode != 4'h5) begin
        chr_q <= tx_data;
        wait_q <= dly;
      end else if (wait_q != 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule // dlst_loop_model

/* File: sim/datacomm_loopback_self_test_tb.sv */
// Bench for the self-test sequencer with a loopback hood model.
// Assumes the model and checker are compiled before this file.
`timescale 1ns/1ns
`include "dlst_defines.svh"
module datacomm_loopback_self_test_tb import dlst_pkg::*; ;
  // Stimulus, driven at the falling edge
  logic clk = 1'b0, arst_n = 1'b0, start_req = 1'b0, mfg_req = 1'b0, cfg_enable = 1'b0;
  logic port_sel = 1'b0, modem_mode = 1'b0, ack_key = 1'b0, soft_rst = 1'b0, hard_rst = 1'b0;
  logic nv_mfg_in = 1'b0, nv_halt_in = 1'b0, nv_halt_port = 1'b0;
  logic [2:0] cur_rate = 3'h7;
  logic [3:0] nv_halt_code = 4'h0, nv_rec_count = 4'h0, nv_rd_code = 4'h0, mode = 4'h0;
  logic [7:0] dly = 8'h02;
  // Observed signals
  logic conn_present_pin, rx_valid, rx_frame_err, rx_overrun, baud_tick, async_mode, tx_valid;
  logic screen_blank, testing_msg, status_show, beep, restore_keys, test_mode, err_valid, err_port;
  logic screen_clear, print_req, nv_wr, nv_wr_halt, nv_mfg_out;
  logic [1:0] ctl_in_pin, ctl_out;
  logic [2:0] baud_sel;
  logic [7:0] tx_data, rx_data;
  logic [3:0] err_code, nv_rd_idx;
  dlst_pat_t pattern_sel;
  int errors = 0, comparisons = 0, txn = 0, clr_n = 0;

  dlst_self_test #(.PRINT_CYC(2000)) DUT (.*);
  dlst_loop_model u_hood (.*);

  // Clock and event counters
  always #10 clk = ~clk;
  always @(negedge clk) if (tx_valid === 1'b1) txn++;
  always @(negedge clk) if (screen_clear === 1'b1) clr_n++;

  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(string what, logic [3:0] exp, logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic press(ref logic key);
    key = 1'b1;
    cyc(1);
    key = 1'b0;
    cyc(3);
  endtask

  // Standalone run with one fault; code 0 expects a pass
  task automatic run_case(logic [3:0] code, logic port, logic mdm);
    int n;
    mode = code;
    port_sel = port;
    modem_mode = mdm;
    dly = mdm ? 8'hc8 : 8'h02;
    cyc(6); // Let the connector sense pass its synchroniser
    txn = 0;
    n = 0;
    press(start_req);
    check("active", (code == 4'h1 && !mdm) ? 4'hd : 4'hf, {test_mode, screen_blank, testing_msg, async_mode});
    check("baud_sel", {1'b0, cur_rate}, {1'b0, baud_sel});
    while (beep !== 1'b1 && err_valid !== 1'b1 && n < 50000) begin
      cyc(1);
      n++;
    end
    if (n >= 50000) begin
      errors++;
      results();
    end
    if (code == 4'h0 || mdm) begin
      check("pass", 4'hc, {beep, restore_keys, test_mode, err_valid});
      check("chars", 4'(`DLST_NCHAR), 4'(txn));
      cyc(1);
      check("beep_once", 4'h0, {3'h0, beep});
    end else begin
      check("err_code", code, err_code);
      check("err_port", {3'h0, port}, {3'h0, err_port});
      check("chars", (code < 4'h5) ? 4'h0 : 4'h1, 4'(txn));
      cyc(20);
      check("held", {1'b1, code[2:0]}, {err_valid, err_code[2:0] ^ {2'b00, testing_msg}});
      press(ack_key);
      check("exit", 4'h0, {2'h0, err_valid, test_mode});
    end
  endtask

  // Manufacturing patterns and keyboard resets
  task automatic mfg_case();
    press(mfg_req);
    check("pat_fb", 4'h5, {1'b0, nv_mfg_out, pattern_sel});
    press(ack_key);
    check("pat_hb", 4'h2, {2'h0, pattern_sel});
    press(soft_rst);
    check("pat_soft", 4'h1, {2'h0, pattern_sel});
    press(hard_rst);
    check("hard", 4'h3, {1'b0, nv_mfg_out, pattern_sel == PAT_NONE, clr_n == 1});
  endtask

  // Power-up with a halted record in the store
  task automatic halt_case();
    nv_halt_in = 1'b1;
    nv_halt_code = 4'h6;
    nv_halt_port = 1'b1;
    nv_mfg_in = 1'b1;
    arst_n = 1'b0;
    cyc(3);
    arst_n = 1'b1;
    cyc(4);
    check("halt_code", 4'h6, err_code);
    check("halt_show", 4'h7, {1'b0, nv_mfg_out, err_valid, err_port});
    nv_halt_in = 1'b0;
    press(ack_key);
  endtask

  initial begin
    cyc(3);
    arst_n = 1'b1;
    cyc(3);
    press(start_req);
    check("refused", 4'h0, {3'h0, test_mode});
    cfg_enable = 1'b1;
    run_case(4'h0, 1'b0, 1'b0);
    run_case(4'h1, 1'b1, 1'b1);
    for (int c = 1; c <= 8; c++) run_case(4'(c), c[0], 1'b0);
    mfg_case();
    halt_case();
    results();
  end
endmodule // datacomm_loopback_self_test_tb
